// ### logic/smbtc_defs.svh
`ifndef SMBTC_DEFS_SVH
`define SMBTC_DEFS_SVH

// register word indices; byte address is four times the index
`define SMBTC_IDX_PRIO 14'h1000
`define SMBTC_IDX_STAT 14'h1001
`define SMBTC_IDX_TEST 14'h103E

// priority_mode_register field positions
`define SMBTC_PRIO_MDA 0
`define SMBTC_PRIO_SPECIAL_MODE_FLAG 1

// status register field positions
`define SMBTC_STAT_ACTIVE 0
`define SMBTC_STAT_SLOW 1
`define SMBTC_STAT_BREAK 2
`define SMBTC_STAT_DONE 3
`define SMBTC_STAT_COUNT 16

`define SMBTC_TEST_RESET 8'h00

// serial bit period in E-clock cycles: E/16 and E/104
`define SMBTC_BAUD_DIV_FAST 7'h10
`define SMBTC_BAUD_DIV_SLOW 7'h68
`define SMBTC_SYNC_BYTE 8'hFF
`define SMBTC_IDLE_CHARS 6'h04
`define SMBTC_CHAR_BITS 6'h0A
`define SMBTC_IDLE_BITS (`SMBTC_IDLE_CHARS * `SMBTC_CHAR_BITS)
`define SMBTC_JUMP_ADDR 16'h0000

// vector addressing
`define SMBTC_VEC_BOOT_BASE 16'h00B5
`define SMBTC_VEC_BOOT_RESET 16'hBF40
`define SMBTC_VEC_TEST_TOP 16'hBFFE
`define SMBTC_VEC_NORM_TOP 16'hFFFE
`define SMBTC_VEC_RESET_SEL 5'h19

`define SMBTC_RAM_AW 9

`endif

// ### logic/smbtc_pkg.sv
`include "smbtc_defs.svh"

package smbtc_pkg;

  typedef enum logic [1:0] {LD_OFF, LD_FIRST, LD_LOAD, LD_DONE} smbtc_ld_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} smbtc_rx_e;

  typedef struct packed {
    logic illegal_opcode_test;
    logic pwm_scaled_clock_test;
    logic flags_to_timer_port;
    logic timer1_chain_bypass;
    logic fault_reset_disable;
    logic force_clock_monitor_fail;
    logic force_watchdog_fail;
    logic timer2_chain_bypass;
  } smbtc_test_s;

  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } smbtc_ccr_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } smbtc_wb_req_s;

  typedef struct packed {
    smbtc_rx_e st;
    logic [6:0] cnt;
    logic [2:0] bits;
    logic [7:0] sh;
    logic valid;
    logic [7:0] data;
    logic idle;
  } smbtc_rx_s;

  typedef struct packed {
    logic special_mode_flag;
    logic mode_a_select_flag;
    smbtc_test_s test;
    smbtc_ld_e ld;
    logic slow;
    logic brk;
    logic [`SMBTC_RAM_AW:0] cnt;
    logic [5:0] idle_bits;
    logic ram_we;
    logic [`SMBTC_RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic jump;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [6:0] tx_div;
    logic txd;
    logic ack;
    logic [31:0] dat;
    logic [15:0] vec;
    logic [7:0] tport;
    logic [7:0] pwm_rd;
    logic pwm_clk;
  } smbtc_state_s;

endpackage

// ### logic/smbtc_serial_rx.sv
`timescale 1ns/1ps
`include "smbtc_defs.svh"

module smbtc_serial_rx
  import smbtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] div_i,
  input wire logic rxd_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic idle_tick_o
);

  smbtc_rx_s q;
  smbtc_rx_s d;
  logic [6:0] last;
  logic [6:0] half;

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.idle = 1'b0;
    last = div_i - 7'h01;
    half = {1'b0, div_i[6:1]} - 7'h01;
    d.cnt = q.cnt + 7'h01;
    case (q.st)
      RX_IDLE: begin
        // one idle tick per bit time of high line
        if (!rxd_i) begin
          d.st = RX_START;
          d.cnt = 7'h00;
        end else if (q.cnt == last) begin
          d.idle = 1'b1;
          d.cnt = 7'h00;
        end
      end
      RX_START: begin
        // mid start bit: a glitch that has gone high is dropped
        if (q.cnt == half) begin
          d.cnt = 7'h00;
          d.bits = 3'h0;
          d.st = rxd_i ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (q.cnt == last) begin
          d.cnt = 7'h00;
          d.sh = {rxd_i, q.sh[7:1]};
          d.bits = q.bits + 3'h1;
          if (q.bits == 3'h7) begin
            d.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        // a low stop bit is a framing error and the byte is dropped
        if (q.cnt == last) begin
          d.cnt = 7'h00;
          d.valid = rxd_i;
          d.data = q.sh;
          d.st = RX_IDLE;
        end
      end
      default: begin
        d.st = RX_IDLE;
      end
    endcase
    if (rst_i) begin
      d = '0;
      d.st = RX_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign byte_valid_o = q.valid;
  assign byte_o = q.data;
  assign idle_tick_o = q.idle;

endmodule

// ### logic/smbtc_top.sv
`timescale 1ns/1ps
`include "smbtc_defs.svh"

module smbtc_top
  import smbtc_pkg::*;
#(
  parameter int RAM_DEPTH = 512
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  output logic special_mode_flag_o,
  output logic mode_a_select_flag_o,
  input wire logic serial_rxd_i,
  output logic serial_txd_o,
  output logic ram_we_o,
  output logic [`SMBTC_RAM_AW-1:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic loader_jump_o,
  output logic [15:0] loader_jump_addr_o,
  input wire logic [4:0] vector_sel_i,
  output logic [15:0] vector_addr_o,
  output logic vector_external_o,
  input wire logic insn_first_cycle_i,
  input wire logic illegal_opcode_i,
  output logic illegal_trap_o,
  output logic instruction_fetch_marker_o,
  output logic instruction_fetch_marker_oe_o,
  input wire logic pwm_scaled_clk_i,
  input wire logic [7:0] pwm_scaler_register_i,
  output logic pwm_scaled_clk_o,
  output logic [7:0] pwm_scaler_read_o,
  input wire smbtc_ccr_s ccr_i,
  input wire logic [7:0] timer_port_i,
  output logic [7:0] timer_port_o,
  input wire logic [1:0] prescale_tick_i,
  output logic [1:0] timer_tick_o,
  output logic [1:0] timer_split_o,
  input wire logic clock_monitor_enable_i,
  input wire logic watchdog_disable_i,
  input wire logic watchdog_timeout_i,
  input wire logic clock_fail_i,
  output logic watchdog_reset_o,
  output logic clock_monitor_reset_o
);

  smbtc_state_s q;
  smbtc_state_s d;
  smbtc_wb_req_s req;
  logic hit;
  logic boot_pins;
  logic [6:0] div;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_idle_tick;
  logic [1:0] bypass;
  logic [4:0] vec_gap;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  assign hit = req.cyc & req.stb & ~q.ack;
  assign boot_pins = ~mode_pin_a_i & ~mode_pin_b_i;
  assign div = q.slow ? `SMBTC_BAUD_DIV_SLOW : `SMBTC_BAUD_DIV_FAST;
  assign vec_gap = `SMBTC_VEC_RESET_SEL - vector_sel_i;

  smbtc_serial_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(div),
    .rxd_i(serial_rxd_i),
    .byte_valid_o(rx_valid),
    .byte_o(rx_byte),
    .idle_tick_o(rx_idle_tick)
  );

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.ram_we = 1'b0;
    d.jump = 1'b0;

    // register bus: one wait state, unmapped reads zero, writes ignored
    if (hit) begin
      d.ack = 1'b1;
      d.dat = 32'h0000_0000;
      case (req.adr[15:2])
        `SMBTC_IDX_PRIO: begin
          d.dat[`SMBTC_PRIO_SPECIAL_MODE_FLAG] = q.special_mode_flag;
          d.dat[`SMBTC_PRIO_MDA] = q.mode_a_select_flag;
          if (req.we && req.sel[0]) begin
            // a one is only kept while the flag is still set
            d.special_mode_flag = q.special_mode_flag & req.dat[`SMBTC_PRIO_SPECIAL_MODE_FLAG];
            if (q.special_mode_flag) begin
              d.mode_a_select_flag = req.dat[`SMBTC_PRIO_MDA];
            end
            if (!d.special_mode_flag) begin
              d.test = `SMBTC_TEST_RESET;
            end
          end
        end
        `SMBTC_IDX_STAT: begin
          d.dat[`SMBTC_STAT_ACTIVE] = (q.ld == LD_FIRST) || (q.ld == LD_LOAD);
          d.dat[`SMBTC_STAT_SLOW] = q.slow;
          d.dat[`SMBTC_STAT_BREAK] = q.brk;
          d.dat[`SMBTC_STAT_DONE] = q.ld == LD_DONE;
          d.dat[`SMBTC_STAT_COUNT +: `SMBTC_RAM_AW + 1] = q.cnt;
        end
        `SMBTC_IDX_TEST: begin
          d.dat[7:0] = q.special_mode_flag ? q.test : 8'h00;
          if (req.we && req.sel[0] && q.special_mode_flag) begin
            d.test = req.dat[7:0];
          end
        end
        default: begin
          d.dat = 32'h0000_0000;
        end
      endcase
    end

    // echo transmitter shifting one bit per bit time
    if (q.tx_bits != 4'h0) begin
      if (q.tx_div == div - 7'h01) begin
        d.tx_div = 7'h00;
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_bits = q.tx_bits - 4'h1;
      end else begin
        d.tx_div = q.tx_div + 7'h01;
      end
    end

    // bootstrap loader
    case (q.ld)
      LD_FIRST: begin
        if (rx_valid) begin
          d.brk = 1'b0;
          // anything but FF at E/16 means the host talks at E/104
          d.slow = rx_byte != `SMBTC_SYNC_BYTE;
          d.ld = LD_LOAD;
          d.idle_bits = 6'h00;
          // the first byte is consumed without echo
        end
      end
      LD_LOAD: begin
        if (rx_valid) begin
          d.idle_bits = 6'h00;
          if (q.cnt != RAM_DEPTH[`SMBTC_RAM_AW:0]) begin
            d.ram_we = 1'b1;
            d.ram_addr = q.cnt[`SMBTC_RAM_AW-1:0];
            d.ram_wdata = rx_byte;
            d.cnt = q.cnt + 1'b1;
          end
          if (q.tx_bits == 4'h0) begin
            d.tx_sh = {1'b1, rx_byte, 1'b0};
            d.tx_bits = 4'hA;
            d.tx_div = 7'h00;
          end
        end else if (rx_idle_tick) begin
          if (q.idle_bits == `SMBTC_IDLE_BITS - 6'h01) begin
            d.jump = 1'b1;
            d.ld = LD_DONE;
          end else begin
            d.idle_bits = q.idle_bits + 6'h01;
          end
        end
      end
      default: begin
        d.ld = q.ld;
      end
    endcase

    // held low as a break until the first byte arrives
    if (d.brk) begin
      d.txd = 1'b0;
    end else if (d.tx_bits != 4'h0) begin
      d.txd = d.tx_sh[0];
    end else begin
      d.txd = 1'b1;
    end

    // vector address for the selected source
    if (q.special_mode_flag && !q.mode_a_select_flag) begin
      if (vector_sel_i == `SMBTC_VEC_RESET_SEL) begin
        d.vec = `SMBTC_VEC_BOOT_RESET;
      end else begin
        d.vec = `SMBTC_VEC_BOOT_BASE + 16'(vector_sel_i) * 16'h0003;
      end
    end else if (q.special_mode_flag) begin
      d.vec = `SMBTC_VEC_TEST_TOP - {10'h000, vec_gap, 1'b0};
    end else begin
      d.vec = `SMBTC_VEC_NORM_TOP - {10'h000, vec_gap, 1'b0};
    end

    if (q.test.flags_to_timer_port) begin
      d.tport = {ccr_i.c, ccr_i.v, ccr_i.z, ccr_i.n, ccr_i.h,
                 timer_port_i[2:0]};
    end else begin
      d.tport = timer_port_i;
    end

    // scaled clock replaces bit 0 of the scaler read value
    d.pwm_clk = q.test.pwm_scaled_clock_test & pwm_scaled_clk_i;
    if (q.test.pwm_scaled_clock_test) begin
      d.pwm_rd = {pwm_scaler_register_i[7:1], pwm_scaled_clk_i};
    end else begin
      d.pwm_rd = pwm_scaler_register_i;
    end

    if (rst_i) begin
      d = '0;
      d.special_mode_flag = ~mode_pin_b_i;
      d.mode_a_select_flag = mode_pin_a_i;
      d.test = `SMBTC_TEST_RESET;
      d.test.fault_reset_disable = ~mode_pin_b_i;
      d.ld = boot_pins ? LD_FIRST : LD_OFF;
      d.slow = 1'b0;
      d.brk = boot_pins;
      d.txd = ~boot_pins;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // timer chain bypass per free-running counter
  assign bypass = {q.test.timer2_chain_bypass, q.test.timer1_chain_bypass};
  for (genvar g = 0; g < 2; g++) begin : g_timer
    assign timer_tick_o[g] = bypass[g] | prescale_tick_i[g];
    assign timer_split_o[g] = bypass[g];
  end

  // fault resets; the disable bit wins over every source
  assign watchdog_reset_o = ~q.test.fault_reset_disable &
    ((q.test.force_watchdog_fail & ~watchdog_disable_i) |
     watchdog_timeout_i);
  assign clock_monitor_reset_o = ~q.test.fault_reset_disable &
    clock_monitor_enable_i &
    (q.test.force_clock_monitor_fail | clock_fail_i);

  assign illegal_trap_o = illegal_opcode_i &
    ~q.test.illegal_opcode_test;
  assign instruction_fetch_marker_o = 1'b0;
  assign instruction_fetch_marker_oe_o = ~rst_i & insn_first_cycle_i &
    ~(q.test.illegal_opcode_test & illegal_opcode_i);

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign special_mode_flag_o = q.special_mode_flag;
  assign mode_a_select_flag_o = q.mode_a_select_flag;
  assign serial_txd_o = q.txd;
  assign ram_we_o = q.ram_we;
  assign ram_addr_o = q.ram_addr;
  assign ram_wdata_o = q.ram_wdata;
  assign loader_jump_o = q.jump;
  assign loader_jump_addr_o = `SMBTC_JUMP_ADDR;
  assign vector_addr_o = q.vec;
  assign vector_external_o = q.special_mode_flag & q.mode_a_select_flag;
  assign pwm_scaled_clk_o = q.pwm_clk;
  assign pwm_scaler_read_o = q.pwm_rd;
  assign timer_port_o = q.tport;

endmodule

// ### verif/smbtc_monitor.sv
`timescale 1ns/1ps
module smbtc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic special_mode_flag_o,
  input wire logic mode_a_select_flag_o,
  input wire logic illegal_opcode_i,
  input wire logic illegal_trap_o,
  input wire logic watchdog_disable_i,
  input wire logic watchdog_reset_o,
  input wire logic clock_monitor_enable_i,
  input wire logic clock_monitor_reset_o,
  input wire logic insn_first_cycle_i,
  input wire logic instruction_fetch_marker_o,
  input wire logic instruction_fetch_marker_oe_o,
  input wire logic vector_external_o,
  input wire logic serial_txd_o,
  input wire logic loader_jump_o,
  input wire logic [15:0] loader_jump_addr_o,
  input wire logic [1:0] timer_split_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a: assert property (req_s |=> pulse_s)
    else $error("bus answer missing or too long");
  trap_normal_a: assert property (!special_mode_flag_o && illegal_opcode_i
    |-> illegal_trap_o) else $error("trap suppressed in normal mode");
  wd_block_a: assert property (watchdog_disable_i |-> !watchdog_reset_o)
    else $error("watchdog reset while disabled");
  cm_block_a: assert property (!clock_monitor_enable_i
    |-> !clock_monitor_reset_o) else $error("monitor reset while off");
  special_mode_flag_stuck_a: assert property (!special_mode_flag_o
    |=> !special_mode_flag_o) else $error("special flag set again");
  marker_first_a: assert property (instruction_fetch_marker_oe_o
    |-> insn_first_cycle_i && !instruction_fetch_marker_o)
    else $error("marker outside first cycle");
  ext_vec_a: assert property (vector_external_o ==
    (special_mode_flag_o && mode_a_select_flag_o))
    else $error("external vector select wrong");
  boot_break_a: assert property ($fell(rst_i) && special_mode_flag_o
    && !mode_a_select_flag_o |-> !serial_txd_o)
    else $error("no break after boot reset");
  jump_pulse_a: assert property (loader_jump_o
    |-> loader_jump_addr_o == 16'h0000 ##1 !loader_jump_o)
    else $error("loader jump wrong");
  split_normal_a: assert property (!special_mode_flag_o
    |-> timer_split_o == 2'b00) else $error("timer split in normal mode");
endmodule

bind smbtc_top smbtc_monitor mon (.*);

// ### verif/smbtc_host.sv
`timescale 1ns/1ps
module smbtc_host (
  input wire logic clk_i,
  output logic txd_o
);
  initial txd_o = 1'b1;
  // one 8N1 frame, LSB first, line idles high between frames
  task automatic send(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      txd_o <= f[i];
      repeat (div - 1) @(posedge clk_i);
    end
  endtask
endmodule

// ### verif/tb_special_mode_boot_and_test_control.sv
`timescale 1ns/1ps
`include "smbtc_defs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_special_mode_boot_and_test_control
  import smbtc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [15:0] wb_adr_i = 0, loader_jump_addr_o, vector_addr_o;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, r;
  logic wb_ack_o, mode_pin_a_i = 0, mode_pin_b_i = 0, special_mode_flag_o;
  logic mode_a_select_flag_o, serial_rxd_i, serial_txd_o, ram_we_o;
  logic [8:0] ram_addr_o;
  logic [7:0] ram_wdata_o, pwm_scaler_register_i = 8'h5A, pwm_scaler_read_o;
  logic loader_jump_o, vector_external_o, insn_first_cycle_i = 0;
  logic [4:0] vector_sel_i = 0;
  logic illegal_opcode_i = 0, illegal_trap_o, instruction_fetch_marker_o;
  logic instruction_fetch_marker_oe_o, pwm_scaled_clk_i = 0, pwm_scaled_clk_o;
  smbtc_ccr_s ccr_i = 5'h16;
  logic [7:0] timer_port_i = 8'h00, timer_port_o;
  logic [1:0] prescale_tick_i = 0, timer_tick_o, timer_split_o;
  logic clock_monitor_enable_i = 1, watchdog_disable_i = 0;
  logic watchdog_timeout_i = 0, clock_fail_i = 0, watchdog_reset_o;
  logic clock_monitor_reset_o;
  int error_cnt = 0, checks_done = 0;
  logic [16:0] got[$];

  smbtc_top dut (.*);
  smbtc_host host (.clk_i(clk_i), .txd_o(serial_rxd_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (ram_we_o === 1'b1) begin
    got.push_back({ram_addr_o, ram_wdata_o});
  end

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
    r = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_sel_i <= 4'h0;
  endtask

  task automatic boot(input logic a, input logic b);
    mode_pin_a_i <= a;
    mode_pin_b_i <= b;
    rst_i <= 1;
    tick(3);
    rst_i <= 0;
    tick(1);
  endtask

  task automatic t_boot();
    logic [4:0] k;
    boot(0, 0);
    `CHK("special_mode_flag", 1'b1, special_mode_flag_o)
    `CHK("mda", 1'b0, mode_a_select_flag_o)
    `CHK("txd", 1'b0, serial_txd_o)
    wb(0, `SMBTC_IDX_TEST, 0);
    `CHK("test", 32'h8, r)
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 5'h00 : (i == 1) ? 5'h18 : 5'h19;
      vector_sel_i <= k;
      tick(2);
      `CHK("vec", (k == 5'h19) ? 16'hBF40 : 16'h00B5 + 3 * k,
        vector_addr_o)
    end
  endtask

  task automatic t_load();
    int n;
    host.send(8'hFF, 16);
    tick(3);
    `CHK("no_echo", 1'b1, serial_txd_o)
    host.send(8'hA5, 16);
    host.send(8'h3C, 16);
    n = 0;
    while (loader_jump_o !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    `CHK("jump", 1'b1, loader_jump_o)
    if (n >= 3000) conclude();
    `CHK("jaddr", 16'h0000, loader_jump_addr_o)
    `CHK("nbytes", 2, got.size())
    `CHK("b0", 17'h000A5, got[0])
    `CHK("b1", 17'h0013C, got[1])
  endtask

  task automatic t_force();
    wb(1, `SMBTC_IDX_TEST, 8'h0E);
    tick(1);
    `CHK("rst_dis", 2'b00, {watchdog_reset_o, clock_monitor_reset_o})
    wb(1, `SMBTC_IDX_TEST, 8'h06);
    tick(1);
    `CHK("rst_on", 2'b11, {watchdog_reset_o, clock_monitor_reset_o})
    clock_monitor_enable_i <= 0;
    watchdog_disable_i <= 1;
    tick(1);
    `CHK("rst_off", 2'b00, {watchdog_reset_o, clock_monitor_reset_o})
    clock_monitor_enable_i <= 1;
    watchdog_disable_i <= 0;
    wb(1, `SMBTC_IDX_TEST, 8'h00);
  endtask

  task automatic t_bits();
    wb(1, `SMBTC_IDX_TEST, 8'hF1);
    illegal_opcode_i <= 1;
    insn_first_cycle_i <= 1;
    pwm_scaled_clk_i <= 1;
    tick(3);
    `CHK("trap", 1'b0, illegal_trap_o)
    `CHK("marker", 1'b0, instruction_fetch_marker_oe_o)
    `CHK("ccr", 5'h0D, timer_port_o[7:3])
    `CHK("split", 2'b11, timer_split_o)
    `CHK("tick", 2'b11, timer_tick_o)
    `CHK("pwm", 2'b11, {pwm_scaled_clk_o, pwm_scaler_read_o[0]})
    illegal_opcode_i <= 0;
    tick(1);
    `CHK("marker", 1'b1, instruction_fetch_marker_oe_o)
    wb(1, `SMBTC_IDX_TEST, 8'h00);
    insn_first_cycle_i <= 0;
  endtask

  task automatic t_testmode();
    boot(1, 0);
    vector_sel_i <= 5'h19;
    tick(2);
    `CHK("vext", 1'b1, vector_external_o)
    `CHK("tvec", 16'hBFFE, vector_addr_o)
    wb(1, `SMBTC_IDX_PRIO, 8'h01);
    wb(1, `SMBTC_IDX_PRIO, 8'h03);
    wb(0, `SMBTC_IDX_PRIO, 0);
    `CHK("prio", 2'b01, r[1:0])
    wb(1, `SMBTC_IDX_TEST, 8'hFF);
    wb(0, `SMBTC_IDX_TEST, 0);
    `CHK("test_lock", 32'h0, r)
  endtask

  task automatic t_normal();
    boot(0, 1);
    `CHK("flags", 2'b00, {special_mode_flag_o, mode_a_select_flag_o})
    wb(0, `SMBTC_IDX_TEST, 0);
    `CHK("test_nrm", 32'h0, r)
    watchdog_timeout_i <= 1;
    clock_fail_i <= 1;
    tick(1);
    `CHK("nrm_rst", 2'b11, {watchdog_reset_o, clock_monitor_reset_o})
    watchdog_timeout_i <= 0;
    clock_fail_i <= 0;
    wb(1, 14'h0123, 8'h55);
    wb(0, 14'h0123, 0);
    `CHK("unmapped", 32'h0, r)
    boot(1, 1);
    `CHK("flags", 2'b01, {special_mode_flag_o, mode_a_select_flag_o})
  endtask

  // host at the slow rate: its FF decodes as E0 at the fast rate
  task automatic t_slow();
    boot(0, 0);
    wb(0, `SMBTC_IDX_STAT, 0);
    `CHK("stat0", 4'h5, r[3:0])
    host.send(8'hFF, 104);
    tick(3);
    wb(0, `SMBTC_IDX_STAT, 0);
    `CHK("stat1", 4'h3, r[3:0])
    host.send(8'h42, 104);
    tick(200);
    `CHK("nslow", 3, got.size())
    `CHK("slow_byte", 17'h00042, got[got.size() - 1])
  endtask

  initial begin
    t_boot();
    t_load();
    t_force();
    t_bits();
    t_testmode();
    t_normal();
    t_slow();
    conclude();
  end
endmodule
